// *** hdl/otg_regs_pkg.sv ***
// constants for the bus line, power control and interrupt register bank
// Contract
// - control register at set 06h, clear 07h
// - ones set or clear; zeros leave bits
// - bits 0,1 pull-ups, reset low
// - bits 2,3 pull-downs, reset high
// - bit 4 grounds id pin, reset low
// - bits 5,6,7 drive, bleed, precharge; reset low
// - setting source clears bleed and precharge
// - bleed clears others; source wins over bleed
// - precharge alone clears others; zero untouched
// - live source register read-only at 08h
// - bits 0,1 vbus valid and session valid
// - bits 2,4 data line high comparators
// - bit 3 id grounded, bit 5 open
// - bit 6 auto connect done when allowed
// - bit 7 session end or level, selectable
// - latch holds events until cleared
// - falling and rising enables per condition
// - latch and enables use set/clear addresses
// - enabled edge sets latch; 0Ah/0Bh
// - falling 0Ch/0Dh, rising 0Eh/0Fh
// - disconnect seen while auto connect allowed raises plus pull-up
package otg_regs_pkg;

  localparam logic [7:0] ctrl_set_addr       = 8'h06;
  localparam logic [7:0] ctrl_clr_addr       = 8'h07;
  localparam logic [7:0] source_addr         = 8'h08;
  localparam logic [7:0] latch_set_addr      = 8'h0a;
  localparam logic [7:0] latch_clr_addr      = 8'h0b;
  localparam logic [7:0] fall_en_set_addr    = 8'h0c;
  localparam logic [7:0] fall_en_clr_addr    = 8'h0d;
  localparam logic [7:0] rise_en_set_addr    = 8'h0e;
  localparam logic [7:0] rise_en_clr_addr    = 8'h0f;

  // control register bit positions
  localparam int plus_pull_up_bit    = 0;
  localparam int minus_pull_up_bit   = 1;
  localparam int plus_pull_down_bit  = 2;
  localparam int minus_pull_down_bit = 3;
  localparam int id_ground_bit       = 4;
  localparam int power_source_bit    = 5;
  localparam int power_bleed_bit     = 6;
  localparam int power_precharge_bit = 7;

  localparam logic [7:0] ctrl_reset    = 8'h0c;
  localparam logic [7:0] latch_reset   = 8'h00;
  localparam logic [7:0] edge_en_reset = 8'h00;

endpackage

// *** hdl/otg_bus_control_and_irq_status.sv ***
// bus line and power control, live source, latch and edge enable registers
`timescale 1ns/10ps
module otg_bus_control_and_irq_status (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,

  // byte register port behind the two-wire slave
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  output logic            reg_wr_refused,

  // comparator levels
  input  wire logic       vbus_valid_cmp,
  input  wire logic       session_valid_cmp,
  input  wire logic       plus_line_high,
  input  wire logic       minus_line_high,
  input  wire logic       id_grounded,
  input  wire logic       id_open,
  input  wire logic       session_end_cmp,
  input  wire logic       plus_line_level_cmp,

  // control bits held in other registers
  input  wire logic       session_end_select,
  input  wire logic       auto_connect_allow,
  input  wire logic       b_disconnect_seen,

  // analog switch controls
  output logic            plus_line_pull_up_en,
  output logic            minus_line_pull_up_en,
  output logic            plus_line_pull_down_en,
  output logic            minus_line_pull_down_en,
  output logic            id_ground_en,
  output logic            bus_power_source_en,
  output logic            bus_power_bleed_en,
  output logic            bus_power_precharge_en,

  // interrupt latch contents
  output logic      [7:0] latched_events
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] latch;
    logic [7:0] fall_en;
    logic [7:0] rise_en;
    logic [7:0] src_prev;
    logic       acon_done;
    logic [7:0] rdata;
    logic       rd_valid;
    logic       wr_refused;
  } state_t;

  state_t     st_reg;
  state_t     st_next;
  logic [7:0] live_src;
  logic       session_end_or_level_hit;

  // one write strobe per writable index, decoded once
  logic       wr_ctrl_set;
  logic       wr_ctrl_clr;
  logic       wr_latch_set;
  logic       wr_latch_clr;
  logic       wr_fall_set;
  logic       wr_fall_clr;
  logic       wr_rise_set;
  logic       wr_rise_clr;

  // condition edges against the previous cycle's view
  logic [7:0] rises;
  logic [7:0] falls;
  logic [7:0] edge_hits;
  logic       acon_fire;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // write-one-to-set at one address, write-one-to-clear at the other
  function automatic logic [7:0] set_clear(input logic [7:0] cur,
                                           input logic       set_wr,
                                           input logic       clr_wr,
                                           input logic [7:0] d);
    logic [7:0] r;
    r = cur;
    if (set_wr) begin
      r = cur | d;
    end
    if (clr_wr) begin
      r = cur & ~d;
    end
    return r;
  endfunction

  // a write strobe aimed at one index
  function automatic logic write_hit(input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    return wr && addr == target;
  endfunction

  // never source and sink vbus at once; source beats bleed beats charge
  function automatic logic [7:0] power_priority(input logic [7:0] cur,
                                                input logic [7:0] d);
    logic [7:0] r;
    r = cur;
    if (d[otg_regs_pkg::power_source_bit]) begin
      r[otg_regs_pkg::power_source_bit]    = 1'b1;
      r[otg_regs_pkg::power_bleed_bit]     = 1'b0;
      r[otg_regs_pkg::power_precharge_bit] = 1'b0;
    end else if (d[otg_regs_pkg::power_bleed_bit]) begin
      r[otg_regs_pkg::power_source_bit]    = 1'b0;
      r[otg_regs_pkg::power_bleed_bit]     = 1'b1;
      r[otg_regs_pkg::power_precharge_bit] = 1'b0;
    end else if (d[otg_regs_pkg::power_precharge_bit]) begin
      r[otg_regs_pkg::power_source_bit]    = 1'b0;
      r[otg_regs_pkg::power_bleed_bit]     = 1'b0;
      r[otg_regs_pkg::power_precharge_bit] = 1'b1;
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // live conditions

  // the select bit lives in another register, so it arrives as a level
  assign session_end_or_level_hit = session_end_select ?
                                    plus_line_level_cmp :
                                    session_end_cmp;

  always_comb begin
    live_src    = 8'h00;
    live_src[0] = vbus_valid_cmp;
    live_src[1] = session_valid_cmp;
    live_src[2] = plus_line_high;
    live_src[3] = id_grounded;
    live_src[4] = minus_line_high;
    live_src[5] = id_open;
    live_src[6] = auto_connect_allow & st_reg.acon_done;
    live_src[7] = session_end_or_level_hit;
  end

  //////////////////////////////////////////////////////////////////////////
  // write strobes and condition edges

  // control pair
  assign wr_ctrl_set  = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::ctrl_set_addr);
  assign wr_ctrl_clr  = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::ctrl_clr_addr);

  // latch pair
  assign wr_latch_set = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::latch_set_addr);
  assign wr_latch_clr = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::latch_clr_addr);

  // falling enable pair
  assign wr_fall_set  = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::fall_en_set_addr);
  assign wr_fall_clr  = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::fall_en_clr_addr);

  // rising enable pair
  assign wr_rise_set  = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::rise_en_set_addr);
  assign wr_rise_clr  = write_hit(reg_wr, reg_addr,
                                  otg_regs_pkg::rise_en_clr_addr);

  // edges are taken against last cycle so a level never latches twice
  assign rises     = live_src & ~st_reg.src_prev;
  assign falls     = ~live_src & st_reg.src_prev;
  assign edge_hits = (rises & st_reg.rise_en) |
                     (falls & st_reg.fall_en);

  assign acon_fire = auto_connect_allow && b_disconnect_seen;

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic       mapped;
    mapped      = 1'b0;
    st_next     = st_reg;

    st_next.src_prev = live_src;
    st_next.rd_valid = 1'b0;
    st_next.wr_refused = 1'b0;

    // control register: plain set/clear first, then the vbus arbitration
    st_next.ctrl = set_clear(st_reg.ctrl, wr_ctrl_set, wr_ctrl_clr,
                             reg_wdata);
    if (wr_ctrl_set) begin
      st_next.ctrl = power_priority(st_next.ctrl, reg_wdata);
    end

    // a disconnect seen while allowed raises the plus pull-up itself
    if (acon_fire) begin
      st_next.ctrl[otg_regs_pkg::plus_pull_up_bit] = 1'b1;
      st_next.acon_done = 1'b1;
    end else if (!auto_connect_allow) begin
      st_next.acon_done = 1'b0;
    end

    st_next.fall_en = set_clear(st_reg.fall_en,
      wr_fall_set,
      wr_fall_clr,
      reg_wdata);
    st_next.rise_en = set_clear(st_reg.rise_en,
      wr_rise_set,
      wr_rise_clr,
      reg_wdata);

    // an edge landing with a clear write still sets: the event is kept
    st_next.latch = set_clear(st_reg.latch,
      wr_latch_set,
      wr_latch_clr,
      reg_wdata) | edge_hits;

    // read mux: both addresses of a pair show the same contents
    case (reg_addr)
      otg_regs_pkg::ctrl_set_addr,
      otg_regs_pkg::ctrl_clr_addr: begin
        st_next.rdata = st_reg.ctrl;
        mapped = 1'b1;
      end
      otg_regs_pkg::source_addr: begin
        st_next.rdata = live_src;
        mapped = 1'b0;
      end
      otg_regs_pkg::latch_set_addr,
      otg_regs_pkg::latch_clr_addr: begin
        st_next.rdata = st_reg.latch;
        mapped = 1'b1;
      end
      otg_regs_pkg::fall_en_set_addr,
      otg_regs_pkg::fall_en_clr_addr: begin
        st_next.rdata = st_reg.fall_en;
        mapped = 1'b1;
      end
      otg_regs_pkg::rise_en_set_addr,
      otg_regs_pkg::rise_en_clr_addr: begin
        st_next.rdata = st_reg.rise_en;
        mapped = 1'b1;
      end
      default: begin
        st_next.rdata = 8'h00;
        mapped = 1'b0;
      end
    endcase
    if (!reg_rd) begin
      st_next.rdata = st_reg.rdata;
    end
    st_next.rd_valid = reg_rd;
    // the source register is read-only, so a write there is refused too
    st_next.wr_refused = reg_wr && !mapped;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.ctrl       <= otg_regs_pkg::ctrl_reset;
      st_reg.latch      <= otg_regs_pkg::latch_reset;
      st_reg.fall_en    <= otg_regs_pkg::edge_en_reset;
      st_reg.rise_en    <= otg_regs_pkg::edge_en_reset;
      st_reg.src_prev   <= 8'h00;
      st_reg.acon_done  <= 1'b0;
      st_reg.rdata      <= 8'h00;
      st_reg.rd_valid   <= 1'b0;
      st_reg.wr_refused <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign reg_rdata               = st_reg.rdata;
  assign reg_rd_valid            = st_reg.rd_valid;
  assign reg_wr_refused          = st_reg.wr_refused;
  assign plus_line_pull_up_en    =
    st_reg.ctrl[otg_regs_pkg::plus_pull_up_bit];
  assign minus_line_pull_up_en   =
    st_reg.ctrl[otg_regs_pkg::minus_pull_up_bit];
  assign plus_line_pull_down_en  =
    st_reg.ctrl[otg_regs_pkg::plus_pull_down_bit];
  assign minus_line_pull_down_en =
    st_reg.ctrl[otg_regs_pkg::minus_pull_down_bit];
  assign id_ground_en            =
    st_reg.ctrl[otg_regs_pkg::id_ground_bit];
  assign bus_power_source_en     =
    st_reg.ctrl[otg_regs_pkg::power_source_bit];
  assign bus_power_bleed_en      =
    st_reg.ctrl[otg_regs_pkg::power_bleed_bit];
  assign bus_power_precharge_en  =
    st_reg.ctrl[otg_regs_pkg::power_precharge_bit];
  assign latched_events          = st_reg.latch;

endmodule

// *** bench/otg_host_model.sv ***
// host side model driving the byte register port
`timescale 1ns/10ps
module otg_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // released lines show the inverse so a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v,
                    output logic ok);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
    ok = reg_rd_valid;
  endtask
endmodule

// *** bench/otg_bank_chk.sv ***
// port assertions for the register bank
`timescale 1ns/10ps
module otg_bank_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_rd_valid,
  input wire logic       reg_wr_refused,
  // auto connect
  input wire logic       auto_connect_allow,
  input wire logic       b_disconnect_seen,
  // switch controls
  input wire logic       plus_line_pull_up_en,
  input wire logic       minus_line_pull_up_en,
  input wire logic       minus_line_pull_down_en,
  input wire logic       bus_power_source_en,
  input wire logic       bus_power_bleed_en,
  input wire logic       bus_power_precharge_en,
  // interrupt latch
  input wire logic [7:0] latched_events
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire       w_set = reg_wr && reg_addr == otg_regs_pkg::ctrl_set_addr;
  wire       w_clr = reg_wr && reg_addr == otg_regs_pkg::ctrl_clr_addr;
  wire       w_src = reg_wr && reg_addr == otg_regs_pkg::source_addr;
  wire       l_clr = reg_wr && reg_addr == otg_regs_pkg::latch_clr_addr;
  wire [2:0] pw    = {bus_power_precharge_en, bus_power_bleed_en,
                      bus_power_source_en};
  //////////////////////////////////////////////////////////////////////////
  set_bit_a: assert property (
    w_set && reg_wdata[1] |=> minus_line_pull_up_en)
    else $error("set write left bit low");
  clr_bit_a: assert property (
    w_clr && reg_wdata[3] |=> !minus_line_pull_down_en)
    else $error("clear write left bit high");
  source_wins_a: assert property (
    w_set && reg_wdata[5] |=> pw == 3'b001)
    else $error("drive did not clear bleed and precharge");
  bleed_wins_a: assert property (
    w_set && reg_wdata[6:5] == 2'b10 |=> pw == 3'b010)
    else $error("bleed priority wrong");
  precharge_alone_a: assert property (
    w_set && reg_wdata[7:5] == 3'b100 |=> pw == 3'b100)
    else $error("precharge priority wrong");
  power_hold_a: assert property (
    w_set && reg_wdata[7:5] == 3'b000 |=> $stable(pw))
    else $error("zero write moved power bits");
  // valid mirrors the strobe one edge later
  rd_pulse_a: assert property (
    reg_rd_valid == $past(reg_rd))
    else $error("read valid not one cycle after strobe");
  read_quiet_a: assert property (
    reg_rd && !reg_wr |=> $stable(pw))
    else $error("read moved power bits");
  ro_refuse_a: assert property (
    w_src |=> reg_wr_refused)
    else $error("write to source not refused");
  auto_conn_a: assert property (
    auto_connect_allow && b_disconnect_seen |=> plus_line_pull_up_en)
    else $error("auto connect missed");
  latch_hold_a: assert property (
    !l_clr |=> (latched_events & $past(latched_events)) ==
               $past(latched_events))
    else $error("latched event dropped without a clear write");
  cover property (w_set && reg_wdata[5]);
  cover property (reg_wr_refused);
  cover property (auto_connect_allow && b_disconnect_seen);
  cover property (l_clr && latched_events != 8'h00);
endmodule
bind otg_bus_control_and_irq_status otg_bank_chk u_otg_bank_chk (
  .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rd_valid,
  .reg_wr_refused, .auto_connect_allow, .b_disconnect_seen,
  .plus_line_pull_up_en, .minus_line_pull_up_en, .minus_line_pull_down_en,
  .bus_power_source_en, .bus_power_bleed_en, .bus_power_precharge_en,
  .latched_events);

// *** bench/otg_bus_control_and_irq_status_tb.sv ***
// self-checking bench for the register bank
`timescale 1ns/10ps
`define check(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module otg_bus_control_and_irq_status_tb;
  logic clk, nrst, reg_wr, reg_rd, reg_rd_valid, reg_wr_refused, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, latched_events, d;
  logic vbus_valid_cmp, session_valid_cmp, plus_line_high, minus_line_high;
  logic id_grounded, id_open, session_end_cmp, plus_line_level_cmp;
  logic session_end_select, auto_connect_allow, b_disconnect_seen;
  logic plus_line_pull_up_en, minus_line_pull_up_en, plus_line_pull_down_en;
  logic minus_line_pull_down_en, id_ground_en, bus_power_source_en;
  logic bus_power_bleed_en, bus_power_precharge_en;
  int n_errors, comparisons, cycles;
  wire [7:0] ctrl = {bus_power_precharge_en, bus_power_bleed_en,
    bus_power_source_en, id_ground_en, minus_line_pull_down_en,
    plus_line_pull_down_en, minus_line_pull_up_en, plus_line_pull_up_en};
  otg_bus_control_and_irq_status u_otg_bus_control_and_irq_status (.clk,
    .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid,
    .reg_wr_refused, .vbus_valid_cmp, .session_valid_cmp, .plus_line_high,
    .minus_line_high, .id_grounded, .id_open, .session_end_cmp,
    .plus_line_level_cmp, .session_end_select, .auto_connect_allow,
    .b_disconnect_seen, .plus_line_pull_up_en, .minus_line_pull_up_en,
    .plus_line_pull_down_en, .minus_line_pull_down_en, .id_ground_en,
    .bus_power_source_en, .bus_power_bleed_en, .bus_power_precharge_en,
    .latched_events);
  otg_host_model u_otg_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reg_rd_valid);
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    nrst = 1'b0;
    step(4);
    nrst = 1'b1;
    `check("ctrl", 8'h0c, ctrl)
    `check("latch", 8'h00, latched_events)
    u_otg_host_model.rd(8'h07, d, ok);
    `check("rd07", 8'h0c, d)
    `check("valid", 1'b1, ok)
    $display("t_reset done");
  endtask
  task automatic t_ctrl();
    logic [7:0] w[6] = '{8'hff, 8'h40, 8'h80, 8'hc0, 8'h60, 8'ha0};
    logic [7:0] e[6] = '{8'h3f, 8'h5f, 8'h9f, 8'h5f, 8'h3f, 8'h3f};
    for (int i = 0; i < 6; i++) begin
      u_otg_host_model.wr(8'h06, w[i]);
      `check("ctrl set", e[i], ctrl)
    end
    u_otg_host_model.wr(8'h07, 8'h1b);
    `check("ctrl clr", 8'h24, ctrl)
    `check("mapped", 1'b0, reg_wr_refused)
    u_otg_host_model.wr(8'h06, 8'h00);
    u_otg_host_model.rd(8'h06, d, ok);
    `check("rd06", 8'h24, d)
    $display("t_ctrl done");
  endtask
  task automatic t_source();
    logic [8:0] v[3] = '{9'h055, 9'h1aa, 9'h000};
    logic [7:0] x;
    for (int i = 0; i < 3; i++) begin
      {session_end_select, plus_line_level_cmp, session_end_cmp, id_open,
       minus_line_high, id_grounded, plus_line_high, session_valid_cmp,
       vbus_valid_cmp} = v[i];
      u_otg_host_model.rd(8'h08, d, ok);
      x = {v[i][8] ? v[i][7] : v[i][6], 1'b0, v[i][5:0]};
      `check("src", x, d)
    end
    u_otg_host_model.wr(8'h08, 8'hff);
    `check("ro", 1'b1, reg_wr_refused)
    `check("ctrl kept", 8'h24, ctrl)
    u_otg_host_model.rd(8'h09, d, ok);
    `check("rd09", 8'h00, d)
    $display("t_source done");
  endtask
  task automatic t_latch();
    u_otg_host_model.wr(8'h0e, 8'h01);
    u_otg_host_model.wr(8'h0c, 8'h02);
    {session_valid_cmp, vbus_valid_cmp} = 2'b11;
    step(2);
    `check("rise", 8'h01, latched_events)
    {session_valid_cmp, vbus_valid_cmp} = 2'b00;
    step(2);
    `check("fall", 8'h03, latched_events)
    u_otg_host_model.wr(8'h0b, 8'h01);
    `check("clr", 8'h02, latched_events)
    u_otg_host_model.wr(8'h0d, 8'h02);
    u_otg_host_model.wr(8'h0b, 8'h02);
    session_valid_cmp = 1'b1;
    step(1);
    session_valid_cmp = 1'b0;
    step(2);
    `check("off", 8'h00, latched_events)
    u_otg_host_model.wr(8'h0a, 8'h80);
    u_otg_host_model.rd(8'h0b, d, ok);
    `check("set", 8'h80, d)
    $display("t_latch done");
  endtask
  task automatic t_auto();
    auto_connect_allow = 1'b1;
    b_disconnect_seen = 1'b1;
    step(1);
    b_disconnect_seen = 1'b0;
    u_otg_host_model.rd(8'h08, d, ok);
    `check("pull", 1'b1, plus_line_pull_up_en)
    `check("done", 1'b1, d[6])
    auto_connect_allow = 1'b0;
    u_otg_host_model.rd(8'h08, d, ok);
    `check("undone", 1'b0, d[6])
    $display("t_auto done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    nrst = 1'b0;
    {session_end_select, auto_connect_allow, b_disconnect_seen} = 3'h0;
    {plus_line_level_cmp, session_end_cmp, id_open, minus_line_high,
     id_grounded, plus_line_high, session_valid_cmp, vbus_valid_cmp} = 8'h00;
    #1;
    t_reset();
    t_ctrl();
    t_source();
    t_latch();
    t_auto();
    t_reset();
    end_of_test();
  end
endmodule
